// ===== can_irq_regs.vh
`ifndef CAN_IRQ_REGS_VH
`define CAN_IRQ_REGS_VH
// register offsets (8-bit data, byte addresses)
`define OFS_ID0 8'h00
`define OFS_ID1 8'h01
`define OFS_ID2 8'h02
`define OFS_ID3 8'h03
`define OFS_PAY0 8'h04
`define OFS_PAY7 8'h0b
`define OFS_LEN 8'h0c
`define OFS_ABORT_ACK 8'h10
`define OFS_SLOT_SEL 8'h11
`define OFS_ABORT_REQ 8'h12
`define OFS_TX_FLAGS 8'h13
`define OFS_RX_IEN 8'h14
`define OFS_TX_IEN 8'h15
`define OFS_RX_FLAGS 8'h16
`define OFS_CTRL 8'h17
`define OFS_EVT_STAT 8'h18
`define OFS_EVT_MASK 8'h19
// rx flag bit positions
`define BIT_WAKEUP 7
`define BIT_STATUS 6
`define BIT_OVERRUN 1
`define BIT_RXFULL 0
// control bit positions
`define BIT_INIT_REQ 0
`define BIT_WAKE_EN 1
`define BIT_GMASK 2
// id1 fixed bits in extended format
`define BIT_SRR 4
`define BIT_IDE 3
// reset values
`define RST_ABORT_ACK 3'h0
`define RST_SLOT_SEL 3'h0
`define RST_TX_EMPTY 3'h7
`define RST_CTRL 8'h05
// length field width
`define LEN_BITS 4
`endif

// ===== tx_slot_store.v
// three transmit message buffers, 13 bytes each, flip-flop storage
module tx_slot_store #(
  parameter SLOTS = 3,
  parameter BYTES = 13
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // foreground window access
  input wire [1:0] slot,
  input wire [3:0] index,
  input wire wr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  // flat storage, slot major
  reg [7:0] mem [0:SLOTS*BYTES-1];
  wire [5:0] addr;
  integer i;
  assign addr = slot * BYTES[5:0] + {2'h0, index};
  assign rdata = mem[addr];

  // write one byte of the selected slot
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < SLOTS*BYTES; i = i + 1)
        mem[i] <= 8'h00;
    end
    else if (wr)
      mem[addr] <= wdata;
  end
endmodule // tx_slot_store

// ===== event_flags.v
// sticky status bits, cleared by a read; set wins over clear
module event_flags #(
  parameter W = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // events and control
  input wire [W-1:0] set,
  input wire clear_rd,
  input wire [W-1:0] mask,
  // outputs
  output reg [W-1:0] status,
  output wire irq
);
  // status update
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status <= {W{1'b0}};
    else
      status <= (clear_rd ? {W{1'b0}} : status) | set;
  end
  // level output while any unmasked bit stands
  assign irq = |(status & mask);
endmodule // event_flags

// ===== can_abort_ack_buffers_irq.v
// Behaviour
// - init mode holds abort acknowledge at reset
// - abort acknowledge readable, writes ignored
// - set acknowledge when abort replaced sending
// - clear acknowledge when empty flag clears
// - slot select maps buffer into window
// - extended identifier, payload, length byte layout
// - srr and ide both one
// - rtr at bit zero of id3
// - four requests, local enables, global mask
// - error from status/overrun, rx, wakeup sources
// - empty when unscheduled; transmit request
// - rx full set after end of frame
// - rx full set again for next
// - bus activity in sleep sets wakeup
// - error request on overrun or counters
//
// Decided for this implementation: the register offsets and the plain strobed port.
`include "can_irq_regs.vh"
module can_abort_ack_buffers_irq (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  // protocol engine events (one-cycle pulses; init_acknowledge and sleep_state are levels)
  input wire init_acknowledge,
  input wire [2:0] tx_sent,
  input wire [2:0] tx_aborted,
  input wire rx_eof_ok,
  input wire rx_next_fg,
  input wire rx_overrun,
  input wire err_range_change,
  input wire bus_activity,
  input wire sleep_state,
  // to the protocol engine
  output reg init_request,
  output reg [2:0] tx_abort_request,
  output wire [2:0] tx_scheduled,
  // interrupt requests
  output wire wakeup_irq,
  output wire error_irq,
  output wire rx_irq,
  output wire tx_irq,
  output wire event_irq
);
  // software owned registers
  reg [2:0] tx_slot_select; // one-hot slot choice
  reg [2:0] tx_slot_empty; // 1 = buffer not scheduled
  reg [2:0] abort_done_flag; // abort acknowledge bits
  reg [7:0] rx_irq_enable_reg; // wakeup/status/overrun/rxfull enables
  reg [2:0] tx_irq_enable_reg; // per-slot empty enables
  reg wakeup_function_enable;
  reg global_mask; // 1 blocks all four requests
  reg wakeup_flag;
  reg status_change_flag;
  reg overrun_flag;
  reg rx_full_flag;
  reg [3:0] evt_mask;
  // combinational helpers
  wire init_mode;
  wire [1:0] fg_slot;
  wire [3:0] fg_index;
  wire fg_hit;
  wire fg_wr;
  wire [7:0] fg_rdata;
  wire [7:0] fg_shaped;
  wire wake_evt;
  wire [3:0] evt_set;
  wire [3:0] evt_status;
  wire rd_evt;
  wire [2:0] empty_clear;

  // lowest selected slot wins when several bits are set
  function [1:0] pick_slot;
    input [2:0] sel;
    begin
      if (sel[0])
        pick_slot = 2'd0;
      else if (sel[1])
        pick_slot = 2'd1;
      else
        pick_slot = 2'd2;
    end
  endfunction

  // address decode for a given offset, for writes and the event read clear
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign init_mode = init_request & init_acknowledge;
  assign fg_slot = pick_slot(tx_slot_select);
  assign fg_hit = (addr <= `OFS_LEN);
  assign fg_index = addr[3:0];
  assign fg_wr = wr_en & fg_hit & (tx_slot_select != 3'h0);
  assign tx_scheduled = ~tx_slot_empty;
  // empty flag cleared by software writing 1 (schedules buffer)
  assign empty_clear = (wr_en & hit(addr, `OFS_TX_FLAGS)) ? wdata[2:0] : 3'h0;
  assign wake_evt = bus_activity & sleep_state & wakeup_function_enable;

  // buffer storage
  tx_slot_store #(
    .SLOTS(3),
    .BYTES(13)
  ) u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .slot(fg_slot),
    .index(fg_index),
    .wr(fg_wr),
    .wdata(wdata),
    .rdata(fg_rdata)
  );

  // force srr/ide in id1; length keeps low four bits, upper read 0
  assign fg_shaped = (addr == `OFS_ID1) ?
    (fg_rdata | (8'h01 << `BIT_SRR) | (8'h01 << `BIT_IDE)) :
    (addr == `OFS_LEN) ? {4'h0, fg_rdata[`LEN_BITS-1:0]} : fg_rdata;
  // id3 bit 0 is rtr, stored as written

  // control and configuration registers
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_slot_select <= `RST_SLOT_SEL;
      rx_irq_enable_reg <= 8'h00;
      tx_irq_enable_reg <= 3'h0;
      init_request <= 1'b1;
      wakeup_function_enable <= 1'b0;
      global_mask <= 1'b1;
      evt_mask <= 4'h0;
    end
    else if (wr_en)
    begin
      // plain stores
      case (addr)
        `OFS_SLOT_SEL: tx_slot_select <= wdata[2:0];
        `OFS_RX_IEN: rx_irq_enable_reg <= wdata;
        `OFS_TX_IEN: tx_irq_enable_reg <= wdata[2:0];
        `OFS_CTRL:
        begin
          init_request <= wdata[`BIT_INIT_REQ];
          wakeup_function_enable <= wdata[`BIT_WAKE_EN];
          global_mask <= wdata[`BIT_GMASK];
        end
        `OFS_EVT_MASK: evt_mask <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // abort requests: cleared once the slot goes empty
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tx_abort_request <= 3'h0;
    else if (init_mode)
      tx_abort_request <= 3'h0;
    else if (wr_en && hit(addr, `OFS_ABORT_REQ))
      tx_abort_request <= wdata[2:0] & ~tx_slot_empty;
    else
      tx_abort_request <= tx_abort_request & ~tx_slot_empty;
  end

  // empty flags: set when sent or aborted, hardware set wins
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tx_slot_empty <= `RST_TX_EMPTY;
    else if (init_mode)
      tx_slot_empty <= `RST_TX_EMPTY;
    else
      tx_slot_empty <= (tx_slot_empty & ~empty_clear) | tx_sent | tx_aborted;
  end

  // abort acknowledge: no software write path
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      abort_done_flag <= `RST_ABORT_ACK;
    else if (init_mode)
      abort_done_flag <= `RST_ABORT_ACK;
    else
      // set on abort, cleared with the empty flag, else 0 if sent
      abort_done_flag <= ((abort_done_flag & ~empty_clear & ~tx_sent) | tx_aborted);
  end

  // receiver flags: write 1 clears, event set wins
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wakeup_flag <= 1'b0;
      status_change_flag <= 1'b0;
      overrun_flag <= 1'b0;
      rx_full_flag <= 1'b0;
    end
    else
    begin
      wakeup_flag <= (wakeup_flag & ~(wr_en & hit(addr, `OFS_RX_FLAGS) & wdata[`BIT_WAKEUP]))
        | wake_evt;
      status_change_flag <= (status_change_flag
        & ~(wr_en & hit(addr, `OFS_RX_FLAGS) & wdata[`BIT_STATUS])) | err_range_change;
      overrun_flag <= (overrun_flag
        & ~(wr_en & hit(addr, `OFS_RX_FLAGS) & wdata[`BIT_OVERRUN])) | rx_overrun;
      rx_full_flag <= (rx_full_flag & ~(wr_en & hit(addr, `OFS_RX_FLAGS) & wdata[`BIT_RXFULL]))
        | rx_eof_ok | rx_next_fg;
    end
  end

  // four levelled requests, gated by local enable and global mask
  assign wakeup_irq = ~global_mask & wakeup_flag & rx_irq_enable_reg[`BIT_WAKEUP];
  assign error_irq = ~global_mask & ((status_change_flag & rx_irq_enable_reg[`BIT_STATUS])
    | (overrun_flag & rx_irq_enable_reg[`BIT_OVERRUN]));
  assign rx_irq = ~global_mask & rx_full_flag & rx_irq_enable_reg[`BIT_RXFULL];
  assign tx_irq = ~global_mask & |(tx_slot_empty & tx_irq_enable_reg);

  // summary event register, read clears
  assign evt_set = {wake_evt, err_range_change | rx_overrun, rx_eof_ok | rx_next_fg,
    |(tx_sent | tx_aborted)};
  assign rd_evt = rd_en & hit(addr, `OFS_EVT_STAT);
  event_flags #(
    .W(4)
  ) u_evt (
    .ref_clk(ref_clk),
    .rst(rst),
    .set(evt_set),
    .clear_rd(rd_evt),
    .mask(evt_mask),
    .status(evt_status),
    .irq(event_irq)
  );

  // read data, one cycle after the strobe; window reads trust software
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd_en)
    begin
      if (fg_hit)
        rdata <= fg_shaped;
      else
        case (addr)
          `OFS_ABORT_ACK: rdata <= {5'h00, abort_done_flag};
          `OFS_SLOT_SEL: rdata <= {5'h00, tx_slot_select};
          `OFS_ABORT_REQ: rdata <= {5'h00, tx_abort_request};
          `OFS_TX_FLAGS: rdata <= {5'h00, tx_slot_empty};
          `OFS_RX_IEN: rdata <= rx_irq_enable_reg;
          `OFS_TX_IEN: rdata <= {5'h00, tx_irq_enable_reg};
          `OFS_RX_FLAGS: rdata <= {wakeup_flag, status_change_flag, 4'h0, overrun_flag,
            rx_full_flag};
          `OFS_CTRL: rdata <= {5'h00, global_mask, wakeup_function_enable, init_request};
          `OFS_EVT_STAT: rdata <= {4'h0, evt_status};
          `OFS_EVT_MASK: rdata <= {4'h0, evt_mask};
          default: rdata <= 8'h00; // unmapped reads zero
        endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule // can_abort_ack_buffers_irq

// ===== can_irq_chk_assertions.sv
module can_irq_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // engine side
  input wire logic init_request,
  input wire logic init_acknowledge,
  input wire logic [2:0] tx_scheduled,
  input wire logic rx_eof_ok,
  input wire logic rx_next_fg,
  // requests
  input wire logic wakeup_irq,
  input wire logic error_irq,
  input wire logic rx_irq,
  input wire logic tx_irq
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // init mode held, then an acknowledge read inside it
  sequence s_init;
    init_request && init_acknowledge;
  endsequence
  sequence s_init_rd;
    init_request && init_acknowledge && rd_en && addr == 8'h10;
  endsequence
  // slot 0 rescheduled, acknowledge read two cycles on
  sequence s_sched;
    wr_en && addr == 8'h13 && wdata[0];
  endsequence
  sequence s_ack_rd;
    rd_en && addr == 8'h10;
  endsequence
  property p_init;
    s_init ##1 s_init_rd |=> rdata == 8'h00;
  endproperty
  property p_ack_clr;
    s_sched ##2 s_ack_rd |=> !rdata[0];
  endproperty
  property p_len;
    rd_en && addr == 8'h0c |=> rdata[7:4] == 4'h0;
  endproperty
  property p_srr;
    rd_en && addr == 8'h01 |=> rdata[4:3] == 2'b11;
  endproperty
  property p_gmask;
    wr_en && addr == 8'h17 && wdata[2] |=> !(wakeup_irq || error_irq || rx_irq || tx_irq);
  endproperty
  property p_tx;
    &tx_scheduled |-> !tx_irq;
  endproperty
  property p_rx_rise;
    $rose(rx_irq) |-> $past(rx_eof_ok) || $past(rx_next_fg) || $past(wr_en);
  endproperty
  property p_level;
    rx_irq && !wr_en |=> rx_irq;
  endproperty
  a_init: assert property (p_init) else $error("ack not held in init");
  a_ack_clr: assert property (p_ack_clr) else $error("ack kept");
  a_len: assert property (p_len) else $error("length top bits");
  a_srr: assert property (p_srr) else $error("srr ide low");
  a_gmask: assert property (p_gmask) else $error("request under mask");
  a_tx: assert property (p_tx) else $error("tx request, none empty");
  a_rx_rise: assert property (p_rx_rise) else $error("rx request no cause");
  a_level: assert property (p_level) else $error("rx request dropped");
endmodule  // can_irq_chk

bind can_abort_ack_buffers_irq can_irq_chk can_irq_chk_i (.*);

// ===== proto_engine_model.sv
module proto_engine_model #(
  parameter int ACK_DLY = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // from the block, plus the bench's finish command
  input wire logic init_request,
  input wire logic [2:0] tx_scheduled,
  input wire logic [2:0] tx_abort_request,
  input wire logic go,
  // to the block
  output logic init_acknowledge,
  output logic [2:0] tx_sent,
  output logic [2:0] tx_aborted
);
  int cnt;  // handshake lag, so the block meets a slow engine
  // init follows the request late; slots end by abort or by sending
  always @(posedge ref_clk or posedge rst)
    if (rst)
      {cnt, init_acknowledge, tx_sent, tx_aborted} <= '0;
    else
    begin
      cnt <= (init_acknowledge == init_request) ? 0 : cnt + 1;
      if (cnt == ACK_DLY)
        init_acknowledge <= init_request;
      tx_aborted <= go ? tx_scheduled & tx_abort_request : 3'h0;
      tx_sent <= go ? tx_scheduled & ~tx_abort_request : 3'h0;
    end
endmodule  // proto_engine_model

// ===== test_can_abort_ack_buffers_irq.sv
`include "can_irq_regs.vh"
module test_can_abort_ack_buffers_irq;
  timeunit 1ns;
  timeprecision 1ps;
  // bench-driven inputs, observed outputs
  logic ref_clk, rst, wr_en, rd_en, go, rx_eof_ok, rx_next_fg, rx_overrun, err_range_change;
  logic bus_activity, sleep_state, init_acknowledge, init_request;
  logic wakeup_irq, error_irq, rx_irq, tx_irq, event_irq;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] tx_sent, tx_aborted, tx_abort_request, tx_scheduled;
  wire [7:0] irqs = {5'h0, wakeup_irq, error_irq, rx_irq};
  // counters, seed, model state
  int error_cnt = 0, checked = 0, seed = 82, ack, e, n;
  int mem[39];  // model copy of the three windows
  int fb[5] = '{0, 0, 1, 6, 7};  // flag bit per event source
  can_abort_ack_buffers_irq can_abort_ack_buffers_irq_i (.*);
  proto_engine_model #(.ACK_DLY(3)) proto_engine_model_i (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task end_sim;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, changed just after an edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge ref_clk) wr_en <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge ref_clk) {addr, rd_en} <= {a, 1'b1};
    @(posedge ref_clk) rd_en <= 1'b0;
    #1 cmp(rdata & m, exp);
  endtask
  // bounded wait on the engine's init handshake
  task wt(input logic v);
    for (n = 0; n < 50 && init_acknowledge !== v; n++)
      @(posedge ref_clk);
    if (init_acknowledge !== v)
    begin
      error_cnt++;
      end_sim;
    end
    else
      #1;
  endtask
  // engine ends every scheduled slot
  task fin;
    @(posedge ref_clk) go <= 1'b1;
    @(posedge ref_clk) go <= 1'b0;
    @(posedge ref_clk) #1;
  endtask
  // one-cycle pulse of a receive-side source
  task evt(input int k);
    @(posedge ref_clk) {rx_eof_ok, rx_next_fg, rx_overrun, err_range_change} <= 4'b1000 >> k;
    {bus_activity, sleep_state} <= {2{k == 4}};
    @(posedge ref_clk) {rx_eof_ok, rx_next_fg, rx_overrun, err_range_change} <= 4'h0;
    {bus_activity, sleep_state} <= 2'h0;
    #1;
  endtask
  initial
  begin
    {rst, wr_en, rd_en, go, addr, wdata} = {4'h8, 16'h0};
    {rx_eof_ok, rx_next_fg, rx_overrun, err_range_change, bus_activity, sleep_state} = 6'h0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`OFS_CTRL, `RST_CTRL, 8'hff);
    rd(`OFS_ABORT_ACK, 8'h00, 8'hff);
    rd(`OFS_TX_FLAGS, 8'h07, 8'h07);
    rd(8'h1f, 8'h00, 8'hff);
    cmp({7'h0, init_request}, 8'h01);
    wr(`OFS_CTRL, 8'h02);  // leave init, wake-up on, mask off
    wt(1'b0);
    $display("reset test done");
    // random fill of every slot, then read back; empty slots only
    for (int s = 0; s < 39; s++)
    begin
      if (s % 13 == 0)
        wr(`OFS_SLOT_SEL, 8'h1 << (s / 13));
      mem[s] = $random(seed) & 8'hff;
      wr(8'(s % 13), 8'(mem[s]));
    end
    for (int s = 0; s < 39; s++)
    begin
      if (s % 13 == 0)
        wr(`OFS_SLOT_SEL, 8'h1 << (s / 13));
      e = s % 13 == 12 ? mem[s] & 15 : s % 13 == 1 ? mem[s] | 8'h18 : mem[s];
      rd(8'(s % 13), 8'(e), 8'hff);
    end
    $display("window test done");
    // abort slots 0 and 2 while slot 1 goes out
    wr(`OFS_TX_FLAGS, 8'h07);
    cmp({5'h0, tx_scheduled}, 8'h07);
    wr(`OFS_ABORT_REQ, 8'h05);
    fin;
    ack = 7 & 5;
    rd(`OFS_ABORT_ACK, 8'(ack), 8'hff);
    rd(`OFS_TX_FLAGS, 8'h07, 8'h07);
    wr(`OFS_ABORT_REQ, 8'h00);
    wr(`OFS_TX_FLAGS, 8'h01);
    ack = ack & ~1;
    rd(`OFS_ABORT_ACK, 8'(ack), 8'hff);
    fin;
    wr(`OFS_ABORT_ACK, 8'hff);
    rd(`OFS_ABORT_ACK, 8'(ack), 8'hff);
    wr(`OFS_CTRL, 8'h03);
    wt(1'b1);
    rd(`OFS_ABORT_ACK, 8'h00, 8'hff);
    wr(`OFS_CTRL, 8'h02);
    wt(1'b0);
    $display("abort test done");
    // transmit request tracks the enabled empty flag
    wr(`OFS_TX_IEN, 8'h02);
    cmp({7'h0, tx_irq}, 8'h01);
    wr(`OFS_TX_FLAGS, 8'h02);
    cmp({7'h0, tx_irq}, 8'h00);
    fin;
    cmp({7'h0, tx_irq}, 8'h01);
    wr(`OFS_TX_IEN, 8'h00);
    $display("tx request test done");
    // each source: enable gating, global mask, clear
    wr(`OFS_RX_IEN, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      e = k < 2 ? 1 : k < 4 ? 2 : 4;
      evt(k);
      cmp(irqs, 8'h00);
      rd(`OFS_RX_FLAGS, 8'h1 << fb[k], 8'h1 << fb[k]);
      wr(`OFS_RX_IEN, 8'h1 << fb[k]);
      cmp(irqs, 8'(e));
      wr(`OFS_CTRL, 8'h06);
      cmp(irqs, 8'h00);
      wr(`OFS_CTRL, 8'h02);
      wr(`OFS_RX_FLAGS, 8'h1 << fb[k]);
      cmp(irqs, 8'h00);
      wr(`OFS_RX_IEN, 8'h00);
    end
    $display("rx request test done");
    // summary status with only the rx bit unmasked
    wr(`OFS_EVT_MASK, 8'h02);
    rd(`OFS_EVT_STAT, 8'h0f, 8'h0f);
    wr(`OFS_RX_IEN, 8'h01);
    evt(0);
    cmp({7'h0, event_irq}, 8'h01);
    wr(`OFS_RX_IEN, 8'h00);
    rd(`OFS_EVT_STAT, 8'h02, 8'h02);
    cmp({7'h0, event_irq}, 8'h00);
    $display("summary test done");
    end_sim;
  end
endmodule  // test_can_abort_ack_buffers_irq
